//--- inc/srh_consts.svh
// Timing and field constants for the static RAM host controller
`ifndef SRH_CONSTS_SVH
`define SRH_CONSTS_SVH

// System clock period in ns
`define SRH_CLK_PERIOD_NS   100
// Power-on settling wait in us
`define SRH_PWRUP_US        500
// Settling wait in clock cycles, rounded up
`define SRH_PWRUP_CYC       ((`SRH_PWRUP_US * 1000 + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
// Write cycle time in ns, strobe low time in ns
`define SRH_WCYC_NS         450
`define SRH_WPULSE_NS       200
// Read access time in ns
`define SRH_ACCESS_NS       450
// Derived cycle counts, least times rounded up
`define SRH_WPULSE_CYC      ((`SRH_WPULSE_NS + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
`define SRH_ACCESS_CYC      ((`SRH_ACCESS_NS + `SRH_CLK_PERIOD_NS - 1) / `SRH_CLK_PERIOD_NS)
// Reset values of the data and address registers
`define SRH_DATA_RST        4'h0
`define SRH_ADDR_RST        10'h000

`endif

//--- inc/srh_pkg.sv
// Types for the static RAM host controller
package srh_pkg;
    typedef enum logic [2:0] {
        SRH_POWERUP = 3'b000,
        SRH_IDLE    = 3'b001,
        SRH_SETUP   = 3'b010,
        SRH_STROBE  = 3'b011,
        SRH_RELEASE = 3'b100
    } srh_state_t;
endpackage

//--- hdl/srh_ctrl.sv
// Host controller driving a 1024 x 4 asynchronous static RAM
`timescale 1ns/1ps
`default_nettype none
`include "srh_consts.svh"

module srh_ctrl #(
    parameter int PWRUP_CYC = `SRH_PWRUP_CYC,
    parameter int WPULSE_CYC = `SRH_WPULSE_CYC,
    parameter int ACCESS_CYC = `SRH_ACCESS_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // User request side
    input  wire logic       reqValid,
    input  wire logic       reqWrite,
    input  wire logic [9:0] reqIndex,
    input  wire logic [3:0] reqData,
    output var  logic       reqReady,
    output var  logic       rspValid,
    output var  logic [3:0] rspData,
    // Memory pins
    output var  logic [9:0] word_index,
    output var  logic       primary_select_n,
    output var  logic       secondary_select,
    output var  logic       writeStrobe_n,
    output var  logic       output_inhibit,
    input  wire logic [3:0] nibbleLinesIn,
    output var  logic [3:0] nibbleLinesOut,
    output var  logic       nibbleLinesOe
);
    import srh_pkg::*;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    localparam int CW = $clog2(PWRUP_CYC + 1) + 1;

    // One counter serves all waits, so every load must fit in it
    if (PWRUP_CYC < 1) begin : g_bad_pwrup
        $error("srh_ctrl: power-up count must be at least one");
    end
    if (WPULSE_CYC < 1 || WPULSE_CYC > PWRUP_CYC) begin : g_bad_wpulse
        $error("srh_ctrl: write pulse count out of range");
    end
    if (ACCESS_CYC < 1 || ACCESS_CYC > PWRUP_CYC) begin : g_bad_access
        $error("srh_ctrl: access count out of range");
    end

    srh_state_t       state_q;
    logic [CW-1:0]    count_q;
    logic             isWrite_q;
    logic             countDone;
    logic             driveWin;
    logic             selWin;
    logic             busWin;

    assign countDone = (count_q == '0);

    // ------------------------------------------------------------
    // Access windows
    // ------------------------------------------------------------
    // Strobe or read window: setup plus all but the last strobe cycle
    assign driveWin = (state_q == SRH_SETUP) ||
                      (state_q == SRH_STROBE && !countDone);
    // Select opens one cycle early so address settles under it
    assign selWin   = driveWin || (state_q == SRH_IDLE && reqValid);
    // Host data held one cycle past the strobe for hold time
    assign busWin   = (state_q == SRH_SETUP) || (state_q == SRH_STROBE);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_q <= SRH_POWERUP;
            count_q <= CW'(PWRUP_CYC);
        end else begin
            unique case (state_q)
                SRH_POWERUP: begin
                    if (countDone) begin
                        state_q <= SRH_IDLE;
                    end else begin
                        count_q <= count_q - CW'(1);
                    end
                end
                SRH_IDLE: begin
                    // Static array: no refresh cycles are ever issued
                    if (reqValid) begin
                        state_q <= SRH_SETUP;
                    end
                end
                SRH_SETUP: begin
                    state_q <= SRH_STROBE;
                    count_q <= isWrite_q ? CW'(WPULSE_CYC - 1)
                                         : CW'(ACCESS_CYC - 1);
                end
                SRH_STROBE: begin
                    if (countDone) begin
                        state_q <= SRH_RELEASE;
                    end else begin
                        count_q <= count_q - CW'(1);
                    end
                end
                SRH_RELEASE: begin
                    state_q <= SRH_IDLE;
                end
                default: begin
                    state_q <= SRH_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Request capture and address
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            isWrite_q      <= 1'b0;
            word_index     <= `SRH_ADDR_RST;
            nibbleLinesOut <= `SRH_DATA_RST;
        end else if (state_q == SRH_IDLE && reqValid) begin
            // Address moves only while the write strobe is high
            isWrite_q      <= reqWrite;
            word_index     <= reqIndex;
            nibbleLinesOut <= reqData;
        end
    end

    // ------------------------------------------------------------
    // Memory strobes
    // ------------------------------------------------------------
    // Deselected between accesses so a standby part powers down
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            primary_select_n <= 1'b1;
        end else begin
            primary_select_n <= !selWin;
        end
    end

    // Second select mirrors the first so the pair never disagrees
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            secondary_select <= 1'b0;
        end else begin
            secondary_select <= selWin;
        end
    end

    // Write strobe low only inside the select window
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            writeStrobe_n <= 1'b1;
        end else begin
            writeStrobe_n <= !(isWrite_q && driveWin);
        end
    end

    // Memory may drive only on reads
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            output_inhibit <= 1'b1;
        end else begin
            output_inhibit <= !(!isWrite_q && driveWin);
        end
    end

    // Host drives data through the write window
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            nibbleLinesOe <= 1'b0;
        end else begin
            nibbleLinesOe <= isWrite_q && busWin;
        end
    end

    // ------------------------------------------------------------
    // User handshake and read data
    // ------------------------------------------------------------
    // Ready stays low through the power-up wait and busy cycles
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            reqReady <= 1'b0;
        end else begin
            reqReady <= (state_q == SRH_IDLE && !reqValid) ||
                        state_q == SRH_RELEASE;
        end
    end

    // Read data sampled at the end of the access window
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rspValid <= 1'b0;
            rspData  <= `SRH_DATA_RST;
        end else begin
            rspValid <= 1'b0;
            if (state_q == SRH_STROBE && countDone && !isWrite_q) begin
                rspData  <= nibbleLinesIn;
                rspValid <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

//--- test/srh_mem_model.sv
// Behavioural 1024 x 4 static RAM standing at the controller's far side
`timescale 1ns/1ps
`default_nettype none
module srh_mem_model (
    input  wire logic [9:0] word_index,
    input  wire logic       primary_select_n,
    input  wire logic       secondary_select,
    input  wire logic       writeStrobe_n,
    input  wire logic       output_inhibit,
    input  wire logic [3:0] busLevel,
    output var  logic [3:0] memOut,
    output var  logic       memOe
);
    logic [3:0] store [1024];
    logic       sel;
    logic       standby;
    assign sel = !primary_select_n && secondary_select;
    assign standby = !sel;
    always @* if (!standby && !writeStrobe_n) store[word_index] = busLevel;
    assign memOut = store[word_index];
    assign memOe = !standby && writeStrobe_n && !output_inhibit;
endmodule
`default_nettype wire

//--- test/srh_ctrl_checker.sv
// Port assertions for the static RAM host controller
`timescale 1ns/1ps
`default_nettype none
module srh_ctrl_checker (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic       reqReady,
    input wire logic       rspValid,
    input wire logic [9:0] word_index,
    input wire logic       primary_select_n,
    input wire logic       secondary_select,
    input wire logic       writeStrobe_n,
    input wire logic       output_inhibit,
    input wire logic       nibbleLinesOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sel_pair_a: assert property (secondary_select == !primary_select_n)
        else $error("select pins disagree");
    strobe_sel_a: assert property (!writeStrobe_n |-> !primary_select_n)
        else $error("strobe while deselected");
    addr_hold_a: assert property ($changed(word_index) |->
        writeStrobe_n && $past(writeStrobe_n)) else $error("address moved");
    read_win_a: assert property (!output_inhibit |->
        writeStrobe_n && !primary_select_n) else $error("bad read window");
    no_fight_a: assert property (nibbleLinesOe |-> output_inhibit)
        else $error("data lines contended");
    pulse_len_a: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n[*2])
        else $error("write pulse short");
    rsp_after_a: assert property ($fell(output_inhibit) |-> ##[1:8] rspValid)
        else $error("read without answer");
    rsp_pulse_a: assert property (rspValid |=> !rspValid)
        else $error("answer too long");
    pwr_wait_a: assert property ($rose(rst_b) |-> !reqReady[*8])
        else $error("ready before settling");
endmodule
bind srh_ctrl srh_ctrl_checker u_chk (.clk_sys, .rst_b, .reqReady,
    .rspValid, .word_index, .primary_select_n, .secondary_select,
    .writeStrobe_n, .output_inhibit, .nibbleLinesOe);
`default_nettype wire

//--- test/test_static_ram_1k_by_4.sv
// Testbench for the static RAM host controller and a memory model
`timescale 1ns/1ps
`default_nettype none
module test_static_ram_1k_by_4;
    localparam int PWR = 20;
    logic       clk_sys = 1'b0, rst_b = 1'b0, reqValid = 1'b0;
    logic       reqWrite = 1'b0, reqReady, rspValid, memOe, nibbleLinesOe;
    logic       primary_select_n, secondary_select, writeStrobe_n;
    logic       output_inhibit;
    logic [9:0] reqIndex = 10'h000, word_index;
    logic [3:0] reqData = 4'h0, rspData, nibbleLinesOut, memOut, busLevel;
    logic [3:0] floatPat = 4'h0;
    int         error_cnt = 0, n_compared = 0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) floatPat <= floatPat + 4'h3;
    assign busLevel = nibbleLinesOe ? nibbleLinesOut
                    : (memOe ? memOut : floatPat);
    srh_ctrl #(.PWRUP_CYC(PWR)) u_dut (.clk_sys, .rst_b, .reqValid,
        .reqWrite, .reqIndex, .reqData, .reqReady, .rspValid, .rspData,
        .word_index, .primary_select_n, .secondary_select, .writeStrobe_n,
        .output_inhibit, .nibbleLinesIn(busLevel), .nibbleLinesOut,
        .nibbleLinesOe);
    srh_mem_model u_mem (.word_index, .primary_select_n, .secondary_select,
        .writeStrobe_n, .output_inhibit, .busLevel, .memOut, .memOe);
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [9:0] a, input logic [3:0] d);
        int k;
        k = 0;
        @(negedge clk_sys);
        while (reqReady !== 1'b1 && k < 60) begin
            @(negedge clk_sys);
            k++;
        end
        chk(4'(k < 60), 4'h1);
        reqWrite = w;
        reqIndex = a;
        reqData = d;
        reqValid = 1'b1;
        @(negedge clk_sys);
        reqValid = 1'b0;
        k = 0;
        while (!w && rspValid !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        if (!w) begin
            chk({3'h0, rspValid}, 4'h1);
            chk(rspData, d);
        end
    endtask
    task automatic t_power();
        int k;
        k = 0;
        rst_b = 1'b0;
        repeat (8) @(negedge clk_sys);
        rst_b = 1'b1;
        while (reqReady !== 1'b1 && k < 100) begin
            @(negedge clk_sys);
            k++;
        end
        chk(4'(k >= PWR && k < 100), 4'h1);
    endtask
    task automatic t_rw();
        logic [9:0] a [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
        logic [3:0] d [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
        for (int i = 0; i < 4; i++) acc(1'b1, a[i], d[i]);
        for (int i = 0; i < 8; i++) acc(1'b0, a[i%4], d[i%4]);
    endtask
    task automatic t_keep();
        t_power();
        acc(1'b0, 10'h3FF, 4'h5);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        t_power();
        t_rw();
        t_keep();
        tally_and_finish();
    end
    initial begin
        #300000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
